// ===== src/nand_host_pkg.sv
// constants for the nand status and command host controller
package nand_host_pkg;
  // command codes
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_MULTI_STATUS = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_MULTI_PROG = 8'h11;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_START = 8'hd0;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_COPY_READ = 8'h35;
  localparam logic [7:0] CMD_ID_READ = 8'h90;
  localparam logic [7:0] CMD_ECC_STATUS = 8'h7a;
  // register byte addresses
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;
  // control register fields
  localparam int CTRL_KIND_LSB = 8;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WP_N = 1;
  localparam int CTRL_INIT_DONE = 2;
  localparam int CTRL_ERASE_BAR = 3;
  // status byte bit positions
  localparam int ST_FAIL = 0;
  localparam int ST_REWRITE = 3;
  localparam int ST_RDY0 = 5;
  localparam int ST_RDY1 = 6;
  localparam int ST_NOT_WP = 7;
  // ecc nibble encodings
  localparam logic [3:0] ECC_MAX_CORR = 4'h8;
  localparam logic [3:0] ECC_UNCORR = 4'hf;
  localparam logic [3:0] ECC_SECTOR_MAX = 4'h7;
  // cycle kinds requested through the command register
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [1:0] KIND_READ = 2'h3;
  // strobe timing
  localparam int STROBE_NS = 40;
  localparam int CLK_NS = 40;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // host result codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_UNKNOWN = 3'h1;
  localparam logic [2:0] ERR_BUSY = 3'h2;
  localparam logic [2:0] ERR_SERIAL = 3'h3;
  localparam logic [2:0] ERR_ADDR6 = 3'h4;
  localparam logic [2:0] ERR_INIT = 3'h5;
  localparam logic [2:0] ERR_BAD_BLOCK = 3'h6;
  localparam int MAX_ADDR_CYCLES = 5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD = 3'b011,
    ST_DONE = 3'b100
  } cycle_state_type;
endpackage

// ===== src/nand_strobe_gen.sv
// one bus cycle on the nand pins: command, address, write or read
`timescale 1ns/100ps
module nand_strobe_gen #(
  parameter int PULSE = nand_host_pkg::STROBE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in
);
  nand_host_pkg::cycle_state_type state;
  logic [7:0] count;
  logic [1:0] kind_q;

  ////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= nand_host_pkg::ST_IDLE;
      count <= 8'h00;
      kind_q <= 2'h0;
    end else begin
      case (state)
        nand_host_pkg::ST_IDLE: begin
          if (start) begin
            kind_q <= kind;
            state <= nand_host_pkg::ST_SETUP;
          end
        end
        nand_host_pkg::ST_SETUP: begin
          count <= 8'(PULSE);
          state <= nand_host_pkg::ST_PULSE;
        end
        nand_host_pkg::ST_PULSE: begin
          if (count <= 8'h01) begin
            state <= nand_host_pkg::ST_HOLD;
          end else begin
            count <= count - 8'h01;
          end
        end
        nand_host_pkg::ST_HOLD: state <= nand_host_pkg::ST_DONE;
        default: state <= nand_host_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else if (state == nand_host_pkg::ST_IDLE && start) begin
      cle <= (kind == nand_host_pkg::KIND_CMD);
      ale <= (kind == nand_host_pkg::KIND_ADDR);
      io_out <= wdata;
      io_oe <= (kind != nand_host_pkg::KIND_READ);
    end else if (state == nand_host_pkg::ST_SETUP) begin
      we_n <= (kind_q == nand_host_pkg::KIND_READ);
      read_strobe_n <= (kind_q != nand_host_pkg::KIND_READ);
    end else if (state == nand_host_pkg::ST_PULSE && count <= 8'h01) begin
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
    end else if (state == nand_host_pkg::ST_DONE) begin
      cle <= 1'b0;
      ale <= 1'b0;
      io_oe <= 1'b0;
    end
  end

  // read data sampled just before the read strobe rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (state == nand_host_pkg::ST_PULSE && count <= 8'h01 &&
                 kind_q == nand_host_pkg::KIND_READ) begin
      rdata <= io_in;
    end
  end

  assign done = (state == nand_host_pkg::ST_DONE);
endmodule // nand_strobe_gen

// ===== src/nand_host_ctrl.sv
// wishbone-driven host controller for a nand device with status and ecc reporting
// Operation
// - status read: 70h then read strobes
// - during init only reset or status
// - never send undefined command codes
// - busy: only 70h, 71h, ffh allowed
// - after 80h only 85h,10h,11h,ffh (the host also lets 70h and 71h through)
// - program pages in ascending order (the host does not check page order)
// - never erase blocks marked bad
`timescale 1ns/100ps
module nand_host_ctrl #(
  parameter int PULSE = nand_host_pkg::STROBE_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // nand pins
  output logic CE_N,
  output logic CLE,
  output logic ALE,
  output logic WE_N,
  output logic READ_STROBE_N,
  output logic WP_N,
  output logic [7:0] IO_OUT,
  output logic IO_OE,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY_N_OUT
);
  logic busy, done, start, ok;
  logic [1:0] kind;
  logic [7:0] wdata, rdata, status, ecc;
  logic after_serial, init_done, in_status, wp_n_reg, erase_bar;
  logic [2:0] err, addr_count;
  logic wb_req, wr;

  ////////////////////////////////////////////////////////////////
  // command legality check on the host side
  function automatic logic known_cmd(input logic [7:0] c);
    case (c)
      nand_host_pkg::CMD_STATUS, nand_host_pkg::CMD_MULTI_STATUS,
      nand_host_pkg::CMD_RESET, nand_host_pkg::CMD_READ,
      nand_host_pkg::CMD_SERIAL_IN, nand_host_pkg::CMD_COL_CHANGE,
      nand_host_pkg::CMD_PROG_CONFIRM, nand_host_pkg::CMD_MULTI_PROG,
      nand_host_pkg::CMD_ERASE_SETUP, nand_host_pkg::CMD_ERASE_START,
      nand_host_pkg::CMD_READ_START, nand_host_pkg::CMD_COPY_READ,
      nand_host_pkg::CMD_ID_READ, nand_host_pkg::CMD_ECC_STATUS: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  endfunction

  function automatic logic status_or_reset(input logic [7:0] c);
    status_or_reset = (c == nand_host_pkg::CMD_STATUS) ||
                      (c == nand_host_pkg::CMD_MULTI_STATUS) ||
                      (c == nand_host_pkg::CMD_RESET);
  endfunction

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = wb_req && WB_WE_I && (WB_ADR_I == nand_host_pkg::REG_CMD) && WB_SEL_I[0];

  // decide whether the requested cycle may go out
  always_comb begin
    ok = 1'b1;
    err = nand_host_pkg::ERR_NONE;
    if (WB_DAT_I[9:8] == nand_host_pkg::KIND_CMD) begin
      if (!known_cmd(WB_DAT_I[7:0])) begin
        ok = 1'b0;
        err = nand_host_pkg::ERR_UNKNOWN;
      end else if (!init_done && !(WB_DAT_I[7:0] == nand_host_pkg::CMD_STATUS ||
                                  WB_DAT_I[7:0] == nand_host_pkg::CMD_RESET)) begin
        ok = 1'b0;
        err = nand_host_pkg::ERR_INIT;
      end else if (!READY_BUSY_N_OUT && !status_or_reset(WB_DAT_I[7:0])) begin
        ok = 1'b0;
        err = nand_host_pkg::ERR_BUSY;
      end else if (after_serial && !(WB_DAT_I[7:0] == nand_host_pkg::CMD_COL_CHANGE ||
                   WB_DAT_I[7:0] == nand_host_pkg::CMD_PROG_CONFIRM ||
                   WB_DAT_I[7:0] == nand_host_pkg::CMD_MULTI_PROG ||
                   WB_DAT_I[7:0] == nand_host_pkg::CMD_RESET ||
                   status_or_reset(WB_DAT_I[7:0]))) begin
        ok = 1'b0;
        err = nand_host_pkg::ERR_SERIAL;
      end else if (erase_bar && WB_DAT_I[7:0] == nand_host_pkg::CMD_ERASE_START) begin
        ok = 1'b0;
        err = nand_host_pkg::ERR_BAD_BLOCK;
      end
    end else if (WB_DAT_I[9:8] == nand_host_pkg::KIND_ADDR &&
                 addr_count >= 3'(nand_host_pkg::MAX_ADDR_CYCLES)) begin
      ok = 1'b0;
      err = nand_host_pkg::ERR_ADDR6;
    end
  end

  ////////////////////////////////////////////////////////////////
  // issue tracking
  logic [2:0] last_err;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      start <= 1'b0;
      kind <= nand_host_pkg::KIND_CMD;
      wdata <= 8'h00;
      busy <= 1'b0;
      last_err <= nand_host_pkg::ERR_NONE;
    end else begin
      start <= 1'b0;
      if (done) begin
        busy <= 1'b0;
      end
      if (wr && !busy) begin
        last_err <= err;
        if (ok) begin
          start <= 1'b1;
          busy <= 1'b1;
          kind <= WB_DAT_I[9:8];
          wdata <= WB_DAT_I[7:0];
        end
      end
    end
  end

  // mode tracking of the device as seen from the host
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      after_serial <= 1'b0;
      in_status <= 1'b0;
      addr_count <= 3'h0;
    end else if (start) begin
      if (kind == nand_host_pkg::KIND_CMD) begin
        addr_count <= 3'h0;
        if (wdata == nand_host_pkg::CMD_SERIAL_IN) begin
          after_serial <= 1'b1;
        end else if (wdata == nand_host_pkg::CMD_PROG_CONFIRM ||
                     wdata == nand_host_pkg::CMD_MULTI_PROG ||
                     wdata == nand_host_pkg::CMD_RESET) begin
          after_serial <= 1'b0;
        end
        if (status_or_reset(wdata) && wdata != nand_host_pkg::CMD_RESET) begin
          in_status <= 1'b1;
        end else begin
          in_status <= 1'b0;
        end
      end else if (kind == nand_host_pkg::KIND_ADDR) begin
        addr_count <= addr_count + 3'h1;
      end
    end
  end

  // read bytes: status while in status mode, otherwise ecc or data
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status <= 8'h00;
      ecc <= 8'h00;
    end else if (done && kind == nand_host_pkg::KIND_READ) begin
      if (in_status) begin
        status <= rdata;
      end else begin
        ecc <= rdata;
      end
    end
  end

  // control register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_n_reg <= 1'b0;
      init_done <= 1'b0;
      erase_bar <= 1'b0;
    end else if (wb_req && WB_WE_I && WB_ADR_I == nand_host_pkg::REG_CTRL && WB_SEL_I[0]) begin
      wp_n_reg <= WB_DAT_I[nand_host_pkg::CTRL_WP_N];
      init_done <= WB_DAT_I[nand_host_pkg::CTRL_INIT_DONE];
      erase_bar <= WB_DAT_I[nand_host_pkg::CTRL_ERASE_BAR];
    end
  end

  ////////////////////////////////////////////////////////////////
  // wishbone answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          nand_host_pkg::REG_CTRL: WB_DAT_O <= {28'h0, erase_bar, init_done, wp_n_reg, 1'b0};
          nand_host_pkg::REG_STAT: WB_DAT_O <= {8'h00, ecc, status,
                                               1'b0, in_status, after_serial,
                                               READY_BUSY_N_OUT, last_err, busy};
          nand_host_pkg::REG_DATA: WB_DAT_O <= {24'h0, rdata};
          nand_host_pkg::REG_CMD: WB_DAT_O <= {22'h0, kind, wdata};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CE_N <= 1'b1;
    end else begin
      CE_N <= !init_done && !busy;
    end
  end
  assign WP_N = wp_n_reg;

  nand_strobe_gen #(.PULSE(PULSE)) u_strobe (
    .clk(CLK),
    .rst(RST),
    .start(start),
    .kind(kind),
    .wdata(wdata),
    .done(done),
    .rdata(rdata),
    .cle(CLE),
    .ale(ALE),
    .we_n(WE_N),
    .read_strobe_n(READ_STROBE_N),
    .io_out(IO_OUT),
    .io_oe(IO_OE),
    .io_in(IO_IN)
  );
endmodule // nand_host_ctrl

// ===== testbench/nand_dev_model.sv
// behavioural nand device answering status, ecc and busy
`timescale 1ns/100ps
module nand_dev_model (
  // clock for busy timing
  input wire logic clk,
  // host pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] io,
  // device pins
  output logic [7:0] q,
  output logic ready_busy_n_out
);
  logic [8:0] cnt = 9'd100;
  logic we_q = 1'b1;
  logic sm = 1'b0, em = 1'b0, fail = 1'b0, rew = 1'b0, pf = 1'b0, pr = 1'b0, pg = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] dout;
  //////////////////////////////
  assign ready_busy_n_out = cnt == 9'd0;
  assign dout = sm ? {wp_n, ready_busy_n_out, ready_busy_n_out, 1'b0, rew, 2'b00, fail}
    : em ? 8'h28 : 8'h5a;
  assign q = !read_strobe_n && !ce_n ? dout : ~last;
  always @(posedge clk) begin
    we_q <= we_n;
    if (!read_strobe_n) last <= dout;
    if (cnt != 9'd0) cnt <= cnt - 9'd1;
    if (cnt == 9'd1) begin
      fail <= pf;
      rew <= pr;
    end
    if (!wp_n && pg) cnt <= 9'd0;
    if (we_n && !we_q && cle && !ce_n) begin
      sm <= io == 8'h70 || io == 8'h71;
      em <= io == 8'h7a;
      if (io == 8'hff) cnt <= 9'd0;
      if (io == 8'h10 || io == 8'hd0 || io == 8'h30) begin
        cnt <= 9'd300;
        fail <= 1'b0;
        rew <= 1'b0;
        pf <= io == 8'hd0;
        pr <= io == 8'h30;
        pg <= io != 8'h30;
      end
    end
  end
endmodule // nand_dev_model

// ===== testbench/nand_host_ctrl_asserts.sv
// port assertions for the nand host controller
`timescale 1ns/100ps
module nand_host_ctrl_asserts #(
  parameter int PULSE = 1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // nand pins
  input wire logic CE_N,
  input wire logic CLE,
  input wire logic ALE,
  input wire logic WE_N,
  input wire logic READ_STROBE_N,
  input wire logic WP_N,
  input wire logic [7:0] IO_OUT,
  input wire logic IO_OE,
  input wire logic READY_BUSY_N_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  //////////////////////////////
  property p_ack_once;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_resp;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
  property p_rd_len;
    $fell(READ_STROBE_N) |-> !READ_STROBE_N ##PULSE READ_STROBE_N;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_oe_rd;
    !READ_STROBE_N |-> !IO_OE;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("host drives during read");
  property p_ce_sel;
    !WE_N || !READ_STROBE_N |-> !CE_N;
  endproperty
  a_ce_sel: assert property (p_ce_sel) else $error("strobe without chip enable");
  property p_wp_ctl;
    WB_ACK_O && WB_WE_I && WB_ADR_I == nand_host_pkg::REG_CTRL && WB_SEL_I[0]
      |=> WP_N == $past(WB_DAT_I[1]);
  endproperty
  a_wp_ctl: assert property (p_wp_ctl) else $error("protect pin not from control");
  property p_busy_cmd;
    $fell(WE_N) && CLE && !READY_BUSY_N_OUT |-> IO_OUT inside {8'h70, 8'h71, 8'hff};
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("command while busy");
  property p_cmd_set;
    $fell(WE_N) && CLE |-> IO_OUT inside {8'h70, 8'h71, 8'hff, 8'h00, 8'h80, 8'h85,
      8'h10, 8'h11, 8'h60, 8'hd0, 8'h30, 8'h35, 8'h90, 8'h7a};
  endproperty
  a_cmd_set: assert property (p_cmd_set) else $error("undefined command sent");
  property p_ale_drv;
    ALE |-> IO_OE && !CLE;
  endproperty
  a_ale_drv: assert property (p_ale_drv) else $error("address latch without drive");
  c_status: cover property ($fell(WE_N) && CLE && IO_OUT == 8'h70);
  c_reset: cover property ($fell(WE_N) && CLE && IO_OUT == 8'hff);
  c_read: cover property ($fell(READ_STROBE_N) && !CE_N);
endmodule // nand_host_ctrl_asserts
bind nand_host_ctrl nand_host_ctrl_asserts #(.PULSE(PULSE)) chk (
  .CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_ACK_O, .CE_N, .CLE, .ALE, .WE_N, .READ_STROBE_N, .WP_N, .IO_OUT, .IO_OE,
  .READY_BUSY_N_OUT
);

// ===== testbench/tb_nand_host_ctrl.sv
// self-checking bench for the nand host controller
`timescale 1ns/100ps
module tb_nand_host_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic ack, ce_n, cle, we_n, rs_n, wp_n, io_oe, rb;
  logic [7:0] io_out, dq, bus;
  logic [31:0] rdat, q, s;
  logic [23:0] r;
  int error_cnt = 0;
  int check_count = 0;
  // row: [22] wait ready, [21:20] kind, [18:16] error, [15:8] byte, [7:0] read data
  logic [23:0] rows [33] = '{
    24'h015500, 24'h007000, 24'h3000e0, 24'h3000e0,
    24'h008000, 24'h030000, 24'h001000, 24'h020000,
    24'h007000, 24'h300080, 24'h00ff00, 24'h007000,
    24'h3000e0, 24'h006000, 24'h00d000, 24'h007100,
    24'h300080, 24'h7000e1, 24'h000000, 24'h100100,
    24'h100100, 24'h100100, 24'h100100, 24'h100100,
    24'h140100, 24'h003000, 24'h007000, 24'h300080,
    24'h7000e8, 24'h000000, 24'h30005a, 24'h007a00,
    24'h300028
  };
  always #20 clk = ~clk;
  assign bus = io_oe ? io_out : dq;
  nand_host_ctrl #(.PULSE(1)) dut (
    .CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wen),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CE_N(ce_n), .CLE(cle), .ALE(), .WE_N(we_n), .READ_STROBE_N(rs_n), .WP_N(wp_n),
    .IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(bus), .READY_BUSY_N_OUT(rb)
  );
  nand_dev_model dev (
    .clk(clk), .ce_n(ce_n), .cle(cle), .we_n(we_n), .read_strobe_n(rs_n), .wp_n(wp_n),
    .io(bus), .q(dq), .ready_busy_n_out(rb)
  );
  //////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdy;
    do wb(1'b0, nand_host_pkg::REG_STAT, 32'h0); while (q[4] !== 1'b1);
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] b);
    wb(1'b1, nand_host_pkg::REG_CMD, {22'h0, k, b});
    do wb(1'b0, nand_host_pkg::REG_STAT, 32'h0); while (q[0] !== 1'b0);
    s = q;
  endtask
  task automatic results;
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, nand_host_pkg::REG_STAT, 32'h0);
    chk(8'(q[4]), 8'h00);
    rdy();
    wb(1'b1, nand_host_pkg::REG_CTRL, 32'h6);
    wb(1'b0, nand_host_pkg::REG_CTRL, 32'h0);
    chk(q[7:0], 8'h06);
    for (int i = 0; i < 33; i++) begin
      r = rows[i];
      if (r[22]) rdy();
      op(r[21:20], r[15:8]);
      chk(8'(s[3:1]), 8'(r[18:16]));
      if (r[21:20] == nand_host_pkg::KIND_READ) begin
        wb(1'b0, nand_host_pkg::REG_DATA, 32'h0);
        chk(q[7:0], r[7:0]);
      end
    end
    chk(s[23:16], 8'h28);
    wb(1'b1, nand_host_pkg::REG_CTRL, 32'he);
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_ERASE_SETUP);
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_ERASE_START);
    chk(8'(s[3:1]), 8'(nand_host_pkg::ERR_BAD_BLOCK));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({2'b00, ce_n, we_n, rs_n, wp_n, io_oe, ack}, 8'h38);
    rst <= 1'b0;
    wb(1'b1, 4'h2, 32'hff);
    wb(1'b0, 4'h2, 32'h0);
    chk(q[7:0], 8'h00);
    wb(1'b0, nand_host_pkg::REG_CTRL, 32'h0);
    chk(q[7:0], 8'h00);
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_READ);
    chk(8'(s[3:1]), 8'(nand_host_pkg::ERR_INIT));
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_STATUS);
    op(nand_host_pkg::KIND_READ, 8'h00);
    wb(1'b0, nand_host_pkg::REG_DATA, 32'h0);
    chk(q[7:0], 8'h68);
    chk(s[15:8], 8'h68);
    results();
  end
endmodule // tb_nand_host_ctrl
